// File: hdl/sbc_spi_register_interface.sv
module sbc_spi_register_interface #(
    parameter int WAKE_CYC = sbc_spi_pkg::WAKE_FILTER_CYC
) (
    input  wire logic                core_clk_i,
    input  wire logic                srst_i,
    input  wire logic                clk_en_i,
    input  wire logic                sclk_i,
    input  wire logic                cs_n_i,
    input  wire logic                mosi_i,
    output logic                     miso_o,
    output logic                     miso_oe_n_o,
    input  wire logic                reset_mode_i,
    input  wire logic                ext_rst_n_i,
    input  wire sbc_spi_pkg::status_s status_i,
    input  wire logic                lin_bus_i,
    output sbc_spi_pkg::ctrl_s       ctrl_o,
    output sbc_spi_pkg::mode_e       op_mode_o,
    output logic                     wd_clear_o,
    output logic                     lin_tx_en_o,
    output logic                     rxd_o,
    output logic                     wake_irq_o,
    output logic                     wake_reset_o,
    output logic                     power_lost_o
);
    import sbc_spi_pkg::*;

    // ---------------- serial clock domain ----------------
    logic [7:0]  shift_q;
    logic [3:0]  fcnt_q;
    logic [3:0]  addr_q;
    logic [2:0]  ocnt_q;
    logic        miso_q;

    status_s     snap_q;
    logic        snap_pl_q;
    logic [3:0]  snap_isr_q;

    function automatic logic [3:0] summary(input status_s st,
                                           input logic pl);
        summary = {(|st.volt) | pl, |st.lin, |st.highside,
                   |st.lowside};
    endfunction

    function automatic logic [3:0] status_nib(input logic [3:0] a,
                                              input status_s st,
                                              input logic pl,
                                              input logic [3:0] interrupt_source);
        case (a[3:1])
            3'h0:    status_nib = {st.volt, pl};
            3'h1:    status_nib = {2'b00, st.wake_level};
            3'h2:    status_nib = st.lin;
            3'h3:    status_nib = {2'b00, st.highside};
            3'h4:    status_nib = st.lowside;
            3'h5:    status_nib = st.watchdog;
            3'h7:    status_nib = interrupt_source;
            default: status_nib = ZERO_RST;
        endcase
    endfunction

    // sample mosi on falling edge, chip select high clears the frame
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            shift_q <= 8'h00;
            fcnt_q  <= 4'h0;
            addr_q  <= 4'h0;
        end else begin
            shift_q <= {shift_q[6:0], mosi_i};
            if (fcnt_q != CNT_MAX) begin
                fcnt_q <= fcnt_q + 4'h1;
            end
            if (fcnt_q == {1'b0, ADDR_LAST}) begin
                addr_q <= {shift_q[2:0], mosi_i};
            end
        end
    end

    // frame word held at chip select rise, before the clear lands;
    // the core reads it only after the synchronised rise
    logic [7:0]  frame_word_q;
    logic [3:0]  frame_cnt_q;

    always_ff @(posedge cs_n_i) begin
        frame_word_q <= shift_q;
        frame_cnt_q  <= fcnt_q;
    end

    // reply byte: summary nibble, then status of the latched address
    logic [7:0]  reply_w;

    assign reply_w = {summary(snap_q, snap_pl_q),
                      status_nib(addr_q, snap_q, snap_pl_q,
                                 snap_isr_q)};

    // drive reply bits on rising edge, summary first then status
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            ocnt_q <= 3'h0;
            miso_q <= 1'b0;
        end else begin
            ocnt_q <= ocnt_q + 3'h1;
            miso_q <= reply_w[~ocnt_q];
        end
    end

    assign miso_o = miso_q;

    // ---------------- core clock domain ----------------
    logic        cs_m_q, cs_s_q, cs_d_q;
    logic        er_m_q, er_s_q;
    logic        lb_m_q, lb_s_q, lb_d_q;
    status_s     st_m_q, st_s_q;
    ctrl_s       ctrl_q;
    mode_e       op_mode_q;
    logic        wd_clear_q;
    logic        power_lost_q;
    logic        oe_n_q;
    logic        lin_err_q;
    logic        wake_block_q;
    logic        wake_pend_q;
    logic        armed_q;
    logic [15:0] dom_cnt_q;
    logic        wake_irq_q, wake_reset_q;
    logic        tx_en_q, rxd_q;

    logic        frame_end, frame_ok, soft_rst, lin_err;
    logic        wake_evt, low_power;
    logic [3:0]  w_addr, w_data;

    assign frame_end = cs_s_q & ~cs_d_q;
    assign frame_ok  = frame_end & (frame_cnt_q == FRAME_BITS);
    assign w_addr    = frame_word_q[7:4];
    assign w_data    = frame_word_q[3:0];
    assign soft_rst  = reset_mode_i | ~er_s_q;
    assign lin_err   = |st_s_q.lin[3:1];
    assign low_power = (op_mode_q == MODE_STOP) |
                       (op_mode_q == MODE_SLEEP);
    assign wake_evt  = low_power & ~wake_block_q & armed_q &
                       lb_s_q & ~lb_d_q;

    // two-flop synchronisers for pins
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            er_m_q <= 1'b1;
            er_s_q <= 1'b1;
            lb_m_q <= 1'b1;
            lb_s_q <= 1'b1;
            lb_d_q <= 1'b1;
            st_m_q <= '0;
            st_s_q <= '0;
        end else if (clk_en_i) begin
            cs_m_q <= cs_n_i;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            er_m_q <= ext_rst_n_i;
            er_s_q <= er_m_q;
            lb_m_q <= lin_bus_i;
            lb_s_q <= lb_m_q;
            lb_d_q <= lb_s_q;
            st_m_q <= status_i;
            st_s_q <= st_m_q;
        end
    end

    // status snapshot follows while idle, frozen during the frame
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            snap_q     <= '0;
            snap_pl_q  <= 1'b1;
            snap_isr_q <= ISR_NONE;
            oe_n_q     <= 1'b1;
        end else if (clk_en_i) begin
            oe_n_q <= cs_s_q;
            if (cs_s_q) begin
                snap_q     <= st_s_q;
                snap_pl_q  <= power_lost_q;
                snap_isr_q <= wake_pend_q ? ISR_LIN_WAKE
                                          : st_s_q.irq_source;
            end
        end
    end

    // control registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ctrl_q <= '0;
            {ctrl_q.overvolt_cutoff_enable,
             ctrl_q.bus_pullup_enable} <= MODE_RST[3:2];
            ctrl_q.mode <= MODE_NORMAL;
            {ctrl_q.wake2_enable, ctrl_q.wake1_enable} <= WAKE_RST[1:0];
        end else if (clk_en_i) begin
            if (soft_rst) begin
                {ctrl_q.wake2_enable,
                 ctrl_q.wake1_enable} <= WAKE_RST[1:0];
                {ctrl_q.dominant_level_select, ctrl_q.receive_only,
                 ctrl_q.slew} <= LIN_RST;
                {ctrl_q.highside_direct_pwm, ctrl_q.highside_on} <= 2'b00;
                ctrl_q.lowside <= ZERO_RST;
                ctrl_q.irq_mask <= ZERO_RST;
            end else begin
                if (lin_err_q & ~lin_err) begin
                    ctrl_q.receive_only <= 1'b0;
                end
                if (frame_ok) begin
                    case (w_addr)
                        A_MODE: begin
                            ctrl_q.overvolt_cutoff_enable <= w_data[3];
                            ctrl_q.bus_pullup_enable <= w_data[2];
                            ctrl_q.mode <= mode_e'(w_data[1:0]);
                        end
                        A_WAKE_W: begin
                            ctrl_q.wake2_enable <= w_data[1];
                            ctrl_q.wake1_enable <= w_data[0];
                        end
                        A_LIN_W: begin
                            ctrl_q.dominant_level_select <= w_data[3];
                            ctrl_q.receive_only <= w_data[2];
                            ctrl_q.slew <= slew_e'(w_data[1:0]);
                        end
                        A_HS_W: begin
                            ctrl_q.highside_direct_pwm <= w_data[2];
                            ctrl_q.highside_on <= w_data[0];
                        end
                        A_LS_W: ctrl_q.lowside <= w_data;
                        A_TIM_W: begin
                            ctrl_q.timing_field_select <= w_data[3];
                            if (w_data[3]) begin
                                ctrl_q.cyclic_period <= w_data[2:0];
                            end else begin
                                ctrl_q.watchdog_period <= w_data[2:0];
                            end
                        end
                        A_AMUX: begin
                            ctrl_q.divider_select <= w_data[3];
                            ctrl_q.mux_channel <= w_data[2:0];
                        end
                        A_CFG: ctrl_q.cyclic_times_eight <= w_data[2];
                        A_IMR: ctrl_q.irq_mask <= w_data;
                        default: ;
                    endcase
                end
                if (wake_evt) begin
                    ctrl_q.mode <= MODE_NORMAL;
                end
                if (lin_err) begin
                    ctrl_q.receive_only <= 1'b1;
                end
            end
        end
    end

    // operating mode, watchdog clear and power lost flag
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            op_mode_q    <= MODE_NORMAL;
            wd_clear_q   <= 1'b0;
            power_lost_q <= 1'b1;
            lin_err_q    <= 1'b0;
            wake_block_q <= 1'b0;
        end else if (clk_en_i) begin
            lin_err_q  <= lin_err;
            wd_clear_q <= 1'b0;
            if (soft_rst | wake_evt) begin
                op_mode_q <= MODE_NORMAL;
            end else if (frame_ok && w_addr == A_MODE) begin
                case (mode_e'(w_data[1:0]))
                    MODE_STOP:   op_mode_q <= MODE_STOP;
                    MODE_SLEEP:  op_mode_q <= MODE_SLEEP;
                    MODE_WDCLR: begin
                        op_mode_q  <= MODE_NORMAL;
                        wd_clear_q <= 1'b1;
                    end
                    default:     op_mode_q <= MODE_NORMAL;
                endcase
                wake_block_q <= ctrl_q.receive_only;
            end
            if (frame_ok && w_addr[3:1] == A_MODE[3:1]) begin
                power_lost_q <= 1'b0;
            end
        end
    end

    // bus wake filter: long dominant level then rising edge
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dom_cnt_q    <= 16'h0000;
            armed_q      <= 1'b0;
            wake_pend_q  <= 1'b0;
            wake_irq_q   <= 1'b0;
            wake_reset_q <= 1'b0;
        end else if (clk_en_i) begin
            wake_irq_q   <= 1'b0;
            wake_reset_q <= 1'b0;
            if (lb_s_q | ~low_power) begin
                dom_cnt_q <= 16'h0000;
            end else if (dom_cnt_q != 16'hffff) begin
                dom_cnt_q <= dom_cnt_q + 16'h0001;
            end
            armed_q <= ~lb_s_q & low_power &
                       (dom_cnt_q >= 16'(WAKE_CYC));
            if (frame_end && w_addr[3:1] == A_IMR[3:1]) begin
                wake_pend_q <= 1'b0;
            end
            if (wake_evt) begin
                wake_pend_q <= 1'b1;
                if (op_mode_q == MODE_STOP) begin
                    wake_irq_q <= 1'b1;
                end else begin
                    wake_reset_q <= 1'b1;
                end
            end
        end
    end

    // transmitter enable and receive data pin
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            tx_en_q <= 1'b0;
            rxd_q   <= 1'b1;
        end else if (clk_en_i) begin
            tx_en_q <= (op_mode_q == MODE_NORMAL) &
                       ~ctrl_q.receive_only & ~lin_err;
            if (op_mode_q == MODE_NORMAL ||
                (op_mode_q == MODE_STOP && wake_block_q)) begin
                rxd_q <= lb_s_q;
            end else begin
                rxd_q <= 1'b1;
            end
        end
    end

    assign miso_oe_n_o  = oe_n_q;
    assign ctrl_o       = ctrl_q;
    assign op_mode_o    = op_mode_q;
    assign wd_clear_o   = wd_clear_q;
    assign lin_tx_en_o  = tx_en_q;
    assign rxd_o        = rxd_q;
    assign wake_irq_o   = wake_irq_q;
    assign wake_reset_o = wake_reset_q;
    assign power_lost_o = power_lost_q;

endmodule

// File: hdl/sbc_spi_pkg.sv
package sbc_spi_pkg;

    localparam int          ADDR_W     = 4;
    localparam int          NIB_W      = 4;
    localparam logic [3:0]  FRAME_BITS = 4'h8;
    localparam logic [3:0]  CNT_MAX    = 4'hf;
    localparam logic [2:0]  ADDR_LAST  = 3'h3;
    localparam logic [2:0]  SUM_BITS   = 3'h4;

    localparam logic [3:0]  A_MODE   = 4'h0;
    localparam logic [3:0]  A_VOLT   = 4'h1;
    localparam logic [3:0]  A_WAKE_W = 4'h2;
    localparam logic [3:0]  A_WAKE_R = 4'h3;
    localparam logic [3:0]  A_LIN_W  = 4'h4;
    localparam logic [3:0]  A_LIN_R  = 4'h5;
    localparam logic [3:0]  A_HS_W   = 4'h6;
    localparam logic [3:0]  A_HS_R   = 4'h7;
    localparam logic [3:0]  A_LS_W   = 4'h8;
    localparam logic [3:0]  A_LS_R   = 4'h9;
    localparam logic [3:0]  A_TIM_W  = 4'ha;
    localparam logic [3:0]  A_TIM_R  = 4'hb;
    localparam logic [3:0]  A_AMUX   = 4'hc;
    localparam logic [3:0]  A_CFG    = 4'hd;
    localparam logic [3:0]  A_IMR    = 4'he;
    localparam logic [3:0]  A_ISR    = 4'hf;

    localparam logic [3:0]  MODE_RST = 4'hc;
    localparam logic [3:0]  WAKE_RST = 4'hf;
    localparam logic [3:0]  LIN_RST  = 4'h0;
    localparam logic [3:0]  ZERO_RST = 4'h0;
    localparam logic [3:0]  ISR_NONE     = 4'h0;
    localparam logic [3:0]  ISR_LIN_WAKE = 4'h2;

    localparam int WAKE_FILTER_NS = 100000;
    localparam int CORE_CLK_NS    = 100;
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_STOP   = 2'b01,
        MODE_SLEEP  = 2'b10,
        MODE_WDCLR  = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        SLEW_NORMAL = 2'b00,
        SLEW_SLOW   = 2'b01,
        SLEW_FAST   = 2'b10,
        SLEW_RSVD   = 2'b11
    } slew_e;

    typedef struct packed {
        logic       overvolt_cutoff_enable;
        logic       bus_pullup_enable;
        mode_e      mode;
        logic       wake2_enable;
        logic       wake1_enable;
        logic       dominant_level_select;
        logic       receive_only;
        slew_e      slew;
        logic       highside_direct_pwm;
        logic       highside_on;
        logic [3:0] lowside;
        logic       timing_field_select;
        logic [2:0] watchdog_period;
        logic [2:0] cyclic_period;
        logic       divider_select;
        logic [2:0] mux_channel;
        logic       cyclic_times_eight;
        logic [3:0] irq_mask;
    } ctrl_s;

    typedef struct packed {
        logic [2:0] volt;
        logic [1:0] wake_level;
        logic [3:0] lin;
        logic [1:0] highside;
        logic [3:0] lowside;
        logic [3:0] watchdog;
        logic [3:0] irq_source;
    } status_s;

endpackage

// File: dv/sbc_spi_sva.sv
module sbc_spi_sva (
    input wire logic                 core_clk_i,
    input wire logic                 srst_i,
    input wire logic                 cs_n_i,
    input wire logic                 miso_o,
    input wire logic                 miso_oe_n_o,
    input wire sbc_spi_pkg::status_s status_i,
    input wire sbc_spi_pkg::ctrl_s   ctrl_o,
    input wire sbc_spi_pkg::mode_e   op_mode_o,
    input wire logic                 wd_clear_o,
    input wire logic                 lin_tx_en_o,
    input wire logic                 wake_irq_o,
    input wire logic                 wake_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_spi_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    a_oe_on_start: assert property (
        $fell(cs_n_i) |-> ##[1:4] !miso_oe_n_o)
        else $error("data out not driven at frame start");
    a_oe_off_end: assert property (
        $rose(cs_n_i) |-> ##[1:4] miso_oe_n_o)
        else $error("data out not released at frame end");
    a_miso_idle_low: assert property (
        cs_n_i |-> !miso_o)
        else $error("data out active while deselected");
    a_wd_clear_normal: assert property (
        wd_clear_o |-> op_mode_o == MODE_NORMAL)
        else $error("watchdog clear outside normal mode");
    a_tx_blocked: assert property (
        (op_mode_o == MODE_NORMAL && ctrl_o.receive_only) [*2]
        |-> !lin_tx_en_o)
        else $error("transmitter on in receive only");
    a_auto_receive_only: assert property (
        (|status_i.lin[3:1]) [*6] |-> ctrl_o.receive_only)
        else $error("receive only not set on bus error");
    a_wake_in_stop: assert property (
        wake_irq_o |-> $past(op_mode_o) == MODE_STOP)
        else $error("wake interrupt outside stop");
    a_wake_in_sleep: assert property (
        wake_reset_o |-> $past(op_mode_o) == MODE_SLEEP)
        else $error("wake reset outside sleep");
endmodule

bind sbc_spi_register_interface sbc_spi_sva sbc_spi_sva_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
    .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .status_i(status_i),
    .ctrl_o(ctrl_o), .op_mode_o(op_mode_o), .wd_clear_o(wd_clear_o),
    .lin_tx_en_o(lin_tx_en_o), .wake_irq_o(wake_irq_o),
    .wake_reset_o(wake_reset_o));

// File: dv/spi_master_model.sv
module spi_master_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // a clean select rise at start clears the link-side state
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b1;
        #10;
        cs_n_o = 1'b1;
    end
    // one frame, msb first; counts other than eight make a refusal
    task automatic frame(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        cs_n_o = 1'b0;
        #300;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            mosi_o = (i < 8) ? tx[7 - i] : ~mosi_o;
            #32;
            sclk_o = 1'b0;
            rx = {rx[6:0], miso_i};
            #32;
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #700;
    endtask
endmodule

// File: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_spi_pkg::*;
    logic        clk, srst, clk_en, sclk, cs_n, mosi, miso, oe_n;
    logic        rmode, ext_n, lin, rxd, wdc, tx_en, w_irq, w_rst, pl;
    logic [7:0]  rx, m;
    status_s     st;
    ctrl_s       ctrl;
    mode_e       md;
    int          bad_count = 0, comparisons = 0, n0;
    int          n_wd = 0, n_irq = 0, n_rst = 0;
    wire         miso_pin = oe_n ? 1'bz : miso;
    logic [7:0]  rtab [9] = '{8'h0c, 8'h23, 8'h40, 8'h60, 8'h80, 8'ha0,
                              8'hc0, 8'hd0, 8'he0};
    logic [7:0]  etab [8] = '{8'h23, 8'h40, 8'h60, 8'h80, 8'he0, 8'had,
                              8'hcb, 8'hd4};
    logic [15:0] wtab [14] = '{16'h2d18, 16'h4bb8, 16'h4888, 16'h4998,
                               16'h4aa8, 16'h6f58, 16'h8aa8, 16'h85a7,
                               16'h85a9, 16'ha558, 16'hadd8, 16'hcbb8,
                               16'hdf48, 16'he998};

    sbc_spi_register_interface #(.WAKE_CYC(5))
        sbc_spi_register_interface_inst (
        .core_clk_i(clk), .srst_i(srst), .clk_en_i(clk_en),
        .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_n_o(oe_n), .reset_mode_i(rmode), .ext_rst_n_i(ext_n),
        .status_i(st), .lin_bus_i(lin), .ctrl_o(ctrl), .op_mode_o(md),
        .wd_clear_o(wdc), .lin_tx_en_o(tx_en), .rxd_o(rxd),
        .wake_irq_o(w_irq), .wake_reset_o(w_rst), .power_lost_o(pl));
    spi_master_model spi_master_model_inst (.sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .miso_i(miso_pin));

    always #50 clk = ~clk;
    always @(negedge clk) begin
        if (wdc === 1'b1) n_wd++;
        if (w_irq === 1'b1) n_irq++;
        if (w_rst === 1'b1) n_rst++;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [3:0] a, input logic [3:0] c,
                        input int n = 8);
        @(negedge clk);
        spi_master_model_inst.frame({a, c}, n, rx);
        @(negedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // dominant longer than the filter, then a rising edge
    task automatic bus_pulse();
        lin = 1'b0;
        cyc(20);
        lin = 1'b1;
        cyc(10);
    endtask

    // control field of one write address as seen on ctrl
    function automatic logic [3:0] field(input logic [3:0] a);
        case (a)
            4'h0: field = {ctrl.overvolt_cutoff_enable,
                           ctrl.bus_pullup_enable, ctrl.mode};
            4'h2: field = {2'b00, ctrl.wake2_enable, ctrl.wake1_enable};
            4'h4: field = {ctrl.dominant_level_select, ctrl.receive_only,
                           ctrl.slew};
            4'h6: field = {1'b0, ctrl.highside_direct_pwm, 1'b0,
                           ctrl.highside_on};
            4'h8: field = ctrl.lowside;
            4'ha: field = {ctrl.timing_field_select,
                           ctrl.timing_field_select ? ctrl.cyclic_period
                                                    : ctrl.watchdog_period};
            4'hc: field = {ctrl.divider_select, ctrl.mux_channel};
            4'hd: field = {1'b0, ctrl.cyclic_times_eight, 2'b00};
            default: field = ctrl.irq_mask;
        endcase
    endfunction
    // expected reply once the power lost flag is clear
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        logic [3:0] s;
        case (a[3:1])
            3'h0: s = {st.volt, 1'b0};
            3'h1: s = {2'b00, st.wake_level};
            3'h2: s = st.lin;
            3'h3: s = {2'b00, st.highside};
            3'h4: s = st.lowside;
            3'h5: s = st.watchdog;
            default: s = st.irq_source;
        endcase
        exp_rd = {|st.volt, |st.lin, |st.highside, |st.lowside, s};
    endfunction

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        clk_en = 1'b1;
        rmode = 1'b0;
        ext_n = 1'b1;
        lin = 1'b1;
        st = {3'b101, 2'b10, 4'h0, 2'b01, 4'h9, 4'h6, 4'h0};
        cyc(2);
        srst = 1'b0;
        cyc(4);
        check("lost", pl, 8'h01);
        foreach (rtab[i])
            check("reset", field(rtab[i][7:4]), rtab[i][3:0]);
        xfer(4'h0, 4'h2, 7);
        xfer(4'h0, 4'h2, 9);
        check("mode", field(4'h0), 8'h0c);
        check("lost", pl, 8'h01);
        xfer(4'h1, 4'h0);
        check("reply", rx, 8'hbb);
        check("lost", pl, 8'h00);
        for (int a = 0; a < 16; a++) begin
            xfer(4'(a), a == 0 ? 4'hc : a == 2 ? 4'h3 : 4'h0);
            m = (a / 2 == 6) ? 8'hf0 : 8'hff;
            check("reply", rx & m,
                  exp_rd(4'(a)) & m);
        end
        foreach (wtab[i]) begin
            xfer(wtab[i][15:12], wtab[i][11:8], wtab[i][3:0]);
            check("field", field(wtab[i][15:12]),
                  wtab[i][7:4]);
        end
        ext_n = 1'b0;
        cyc(3);
        ext_n = 1'b1;
        cyc(6);
        foreach (etab[i])
            check("ext", field(etab[i][7:4]), etab[i][3:0]);
        check("lost", pl, 8'h00);
        xfer(4'h8, 4'h3);
        rmode = 1'b1;
        cyc(1);
        rmode = 1'b0;
        cyc(3);
        check("rmode", field(4'h8), 8'h00);
        check("rmode", field(4'ha), 8'h0d);
        n0 = n_wd;
        xfer(4'h0, 4'hf);
        check("wdclr", 8'(n_wd - n0), 8'h01);
        check("mode", md, MODE_NORMAL);
        xfer(4'h4, 4'h4);
        check("txen", tx_en, 8'h00);
        xfer(4'h4, 4'h0);
        check("txen", tx_en, 8'h01);
        cyc(1);
        st.lin = 4'h2;
        cyc(8);
        check("receive_only", field(4'h4), 8'h04);
        check("txen", tx_en, 8'h00);
        st.lin = 4'h0;
        cyc(8);
        xfer(4'h0, 4'hd);
        check("mode", md, MODE_STOP);
        n0 = n_irq;
        bus_pulse();
        check("wake", 8'(n_irq - n0), 8'h01);
        check("mode", md, MODE_NORMAL);
        xfer(4'hf, 4'h0);
        check("source", rx[3:0], ISR_LIN_WAKE);
        xfer(4'h0, 4'he);
        check("mode", md, MODE_SLEEP);
        n0 = n_rst;
        bus_pulse();
        check("wake", 8'(n_rst - n0), 8'h01);
        xfer(4'he, 4'h0);
        check("source", rx[3:0], ISR_LIN_WAKE);
        xfer(4'h4, 4'h4);
        xfer(4'h0, 4'hd);
        n0 = n_irq;
        lin = 1'b0;
        cyc(20);
        check("rxd", rxd, 8'h00);
        lin = 1'b1;
        cyc(10);
        check("rxd", rxd, 8'h01);
        check("wake", 8'(n_irq - n0), 8'h00);
        check("mode", md, MODE_STOP);
        tally_and_finish();
    end

    initial begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
endmodule
